/* hw/umsr_pkg.sv */
// package: register offsets, field positions, reset values and carrier types for umsr
package umsr_pkg;
  // apb byte offsets
  localparam logic [7:0] ADDR_MODEM_LINE   = 8'h00;
  localparam logic [7:0] ADDR_SCRATCH      = 8'h04;
  localparam logic [7:0] ADDR_DIV_LOW      = 8'h08;
  localparam logic [7:0] ADDR_DIV_HIGH     = 8'h0C;
  localparam logic [7:0] ADDR_FRACTION     = 8'h10;
  localparam logic [7:0] ADDR_CONTROL      = 8'h14;
  localparam logic [7:0] ADDR_RX_DIVISOR   = 8'h18;
  localparam logic [7:0] ADDR_STATUS       = 8'h1C;
  // control register fields
  localparam int CTL_LOOPBACK   = 0;
  localparam int CTL_ENHANCED   = 1;
  localparam int CTL_AUTO_CTS   = 2;
  localparam int CTL_SWAP       = 3;
  localparam int CTL_MSI_ENABLE = 4;
  localparam int CTL_RS485      = 5;
  localparam int CTL_FIFO_EN    = 6;
  localparam int CTL_SEL_TRIG   = 7;
  localparam int CTL_MC_BIT0    = 8;
  // field positions
  localparam int EMS_SEND_NOW   = 2;
  localparam int EMS_RTS_INV    = 3;
  localparam int EMS_LSR_IMM    = 6;
  localparam int EMS_XOFF_MODE  = 7;
  localparam int FR_IND_BRG     = 6;
  localparam int FR_BRG_SEL     = 7;
  localparam int FR_SAMP_HI     = 5;
  localparam int FR_SAMP_LO     = 4;
  // reset values
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [8:0] CTL_RST     = 9'h000;
  // sampling rate encodings
  typedef enum logic [1:0] {UMSR_OS16, UMSR_OS8, UMSR_OS4} umsr_rate_t;
  // one baud generator setting
  typedef struct packed {
    logic [15:0] divisor;
    logic [3:0]  fraction;
    umsr_rate_t  rate;
  } umsr_brg_t;
  // modem inputs, active low as pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ring_indicate_in_n;
    logic carrier_detect_in_n;
  } umsr_modem_t;
endpackage

/* hw/umsr_regs.sv */
// umsr_regs: modem status, enhanced enables, scratch swap and fractional baud registers
//
// Behaviour
// - error summary flag set while any fifo byte carries parity, framing or break
// - cts, dsr, cd delta bits set on any change since last status read
// - ring delta bit set only on ring input low-to-high
// - modem status interrupt when a delta is set and its enable is on
// - outside loopback upper status bits are complements of modem inputs
// - in loopback upper status bits mirror modem control bits 1,0,2,3
// - auto cts stops transmit after current character while cts high
// - enhanced write bits 4 and 5 disable transmitter and receiver
// - enhanced write bit 6 selects 9-bit multidrop mode
// - write bit 7 selects fast infrared quarter-bit pulses
// - 8-bit scratch register resets to FF
// - swap set sends scratch writes to the enhanced mode select register
// - swap set reads return rx, tx or alternating fifo level count
// - alternating mode starts with rx level then alternates each read
// - send-immediately bit clears itself after the single byte is sent
// - rs485 direction drives rts low in transmit unless inverted
// - mode bit 6 selects immediate or delayed line error interrupts
// - mode bit 7 limits xoff and special interrupt clearing to status read
// - divisor is high and low bytes plus fraction over 16
// - fractional register reachable only with enhanced functions enabled
// - fraction bits 5:4 select 16x, 8x or 4x sampling
// - fraction bit 6 splits tx and rx generators, bit 7 selects target
// - divisor writes target both, tx, rx, or none by select bits
`timescale 1ns/1ps
module umsr_regs
  import umsr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire umsr_pkg::umsr_modem_t modem_in,
  input  wire logic [7:0]        rx_level,
  input  wire logic [7:0]        tx_level,
  input  wire logic              rx_fifo_error,
  input  wire logic              tx_char_done,
  input  wire logic              tx_active,
  output logic                   modem_irq,
  output logic                   tx_halt,
  output logic                   tx_disable,
  output logic                   rx_disable,
  output logic                   nine_bit_mode,
  output logic                   fast_ir,
  output logic                   send_now,
  output logic                   rts_n_rs485,
  output logic                   lsr_irq_immediate,
  output logic                   xoff_clear_on_read_only,
  output logic                   error_summary,
  output umsr_pkg::umsr_brg_t    tx_brg,
  output umsr_pkg::umsr_brg_t    rx_brg
);
  import umsr_pkg::*;

  logic [8:0]  ctl_q;
  logic [3:0]  delta_q;
  logic [3:0]  modem_prev_q;
  logic [7:0]  scratch_q;
  logic [7:0]  ems_q;
  logic [7:0]  div_lo_q;
  logic [7:0]  div_hi_q;
  logic [7:0]  frac_q;
  logic [7:0]  rx_div_lo_q;
  logic [7:0]  rx_div_hi_q;
  logic [5:0]  rx_frac_q;
  logic        alt_tx_q;
  logic        halt_q;
  logic [3:0]  mcr_q;
  logic [3:0]  modem_ev;
  logic [3:0]  level_now;
  logic [3:0]  status_hi;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        wr_tx_brg;
  logic        wr_rx_brg;
  logic        enh;
  logic [7:0]  rd_d;

  function automatic umsr_rate_t rate_of(input logic [7:0] f);
    if (f[FR_SAMP_HI]) begin
      rate_of = UMSR_OS4;
    end else if (f[FR_SAMP_LO]) begin
      rate_of = UMSR_OS8;
    end else begin
      rate_of = UMSR_OS16;
    end
  endfunction

  assign acc = psel && penable;
  // writes land on the completing edge; read side effects only on the capture edge,
  // so a delta set between capture and completion is not cleared unseen
  assign wr  = acc && pwrite && pready;
  assign rd  = acc && !pwrite && !pready;
  assign enh = ctl_q[CTL_ENHANCED];

  // pins are active low; level bits are their complements
  assign level_now = ~{modem_in.carrier_detect_in_n, modem_in.ring_indicate_in_n,
                       modem_in.dsr_n, modem_in.cts_n};

  // loopback source bits sit in the control word above the enables
  function automatic logic mc_bit(input int idx);
    mc_bit = mcr_q[idx];
  endfunction

  always_comb begin
    if (ctl_q[CTL_LOOPBACK]) begin
      // loopback order cd, ri, dsr, cts from control bits 3, 2, 0, 1
      status_hi = {mc_bit(3), mc_bit(2), mc_bit(0), mc_bit(1)};
    end else begin
      status_hi = level_now;
    end
  end

  // ring delta only at the end of ringing; the other lines on any change
  always_comb begin
    modem_ev    = modem_prev_q ^ status_hi;
    modem_ev[2] = modem_prev_q[2] && !status_hi[2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcr_q <= 4'h0;
    end else if (wr && paddr == ADDR_CONTROL) begin
      mcr_q <= pwdata[12:9];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= CTL_RST;
    end else if (wr && paddr == ADDR_CONTROL) begin
      ctl_q <= pwdata[8:0];
    end
  end

  // delta flags; a change in the read cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_prev_q <= 4'h0;
      delta_q      <= 4'h0;
    end else begin
      modem_prev_q <= status_hi;
      for (int i = 0; i < 4; i++) begin
        if (modem_ev[i]) begin
          delta_q[i] <= 1'b1;
        end else if (rd && paddr == ADDR_MODEM_LINE) begin
          delta_q[i] <= 1'b0;
        end
      end
    end
  end

  // extra enables live in the modem-line write slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_disable    <= 1'b0;
      rx_disable    <= 1'b0;
      nine_bit_mode <= 1'b0;
      fast_ir       <= 1'b0;
    end else if (wr && paddr == ADDR_MODEM_LINE && enh) begin
      tx_disable    <= pwdata[4];
      rx_disable    <= pwdata[5];
      nine_bit_mode <= pwdata[6];
      fast_ir       <= pwdata[7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_q <= SCRATCH_RST;
      ems_q     <= BYTE_RST;
    end else begin
      if (wr && paddr == ADDR_SCRATCH && !ctl_q[CTL_SWAP]) begin
        scratch_q <= pwdata[7:0];
      end
      if (wr && paddr == ADDR_SCRATCH && ctl_q[CTL_SWAP]) begin
        ems_q <= pwdata[7:0];
      end else if (tx_char_done && ems_q[EMS_SEND_NOW]) begin
        ems_q[EMS_SEND_NOW] <= 1'b0;
      end
    end
  end

  // alternating counter: rx first after a mode write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_tx_q <= 1'b0;
    end else if (wr && paddr == ADDR_SCRATCH && ctl_q[CTL_SWAP]) begin
      alt_tx_q <= 1'b0;
    end else if (rd && paddr == ADDR_SCRATCH && ctl_q[CTL_SWAP] && ems_q[1:0] == 2'b11) begin
      alt_tx_q <= !alt_tx_q;
    end
  end

  assign wr_tx_brg = !frac_q[FR_IND_BRG] ? !frac_q[FR_BRG_SEL] : !frac_q[FR_BRG_SEL];
  assign wr_rx_brg = !frac_q[FR_IND_BRG] ? !frac_q[FR_BRG_SEL] : frac_q[FR_BRG_SEL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_lo_q    <= BYTE_RST;
      div_hi_q    <= BYTE_RST;
      frac_q      <= BYTE_RST;
      rx_div_lo_q <= BYTE_RST;
      rx_div_hi_q <= BYTE_RST;
      rx_frac_q   <= 6'h00;
    end else if (wr) begin
      if (paddr == ADDR_FRACTION && enh) begin
        frac_q[7:6] <= pwdata[7:6];
        if (wr_tx_brg) frac_q[5:0] <= pwdata[5:0];
        if (wr_rx_brg) rx_frac_q <= pwdata[5:0];
      end
      if (paddr == ADDR_DIV_LOW) begin
        if (wr_tx_brg) div_lo_q <= pwdata[7:0];
        if (wr_rx_brg) rx_div_lo_q <= pwdata[7:0];
      end
      if (paddr == ADDR_DIV_HIGH) begin
        if (wr_tx_brg) div_hi_q <= pwdata[7:0];
        if (wr_rx_brg) rx_div_hi_q <= pwdata[7:0];
      end
    end
  end

  // flow and status outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q                  <= 1'b0;
      tx_halt                 <= 1'b0;
      modem_irq               <= 1'b0;
      send_now                <= 1'b0;
      rts_n_rs485             <= 1'b1;
      lsr_irq_immediate       <= 1'b0;
      xoff_clear_on_read_only <= 1'b0;
      error_summary           <= 1'b0;
      tx_brg                  <= '0;
      rx_brg                  <= '0;
    end else begin
      // halt only takes effect at a character boundary
      if (!ctl_q[CTL_AUTO_CTS] || !modem_in.cts_n) begin
        halt_q <= 1'b0;
      end else if (tx_char_done || !tx_active) begin
        halt_q <= 1'b1;
      end
      tx_halt   <= halt_q;
      modem_irq <= (|delta_q) && ctl_q[CTL_MSI_ENABLE];
      send_now  <= ems_q[EMS_SEND_NOW] && ctl_q[CTL_FIFO_EN];
      if (ctl_q[CTL_RS485]) begin
        rts_n_rs485 <= tx_active ~^ ems_q[EMS_RTS_INV];
      end else begin
        rts_n_rs485 <= 1'b1;
      end
      lsr_irq_immediate       <= ems_q[EMS_LSR_IMM];
      xoff_clear_on_read_only <= ems_q[EMS_XOFF_MODE];
      error_summary           <= rx_fifo_error;
      tx_brg <= '{divisor: {div_hi_q, div_lo_q}, fraction: frac_q[3:0],
                  rate: rate_of(frac_q)};
      rx_brg <= '{divisor: {rx_div_hi_q, rx_div_lo_q}, fraction: rx_frac_q[3:0],
                  rate: rate_of({2'b00, rx_frac_q})};
    end
  end

  always_comb begin
    rd_d = 8'h00;
    unique case (paddr)
      ADDR_MODEM_LINE: rd_d = {status_hi, delta_q};
      ADDR_SCRATCH: begin
        if (!ctl_q[CTL_SWAP]) begin
          rd_d = scratch_q;
        end else if (ems_q[0] == 1'b0) begin
          rd_d = rx_level;
        end else if (ems_q[1] == 1'b0) begin
          rd_d = tx_level;
        end else begin
          rd_d = alt_tx_q ? tx_level : rx_level;
        end
      end
      ADDR_DIV_LOW:    rd_d = frac_q[FR_BRG_SEL] ? rx_div_lo_q : div_lo_q;
      ADDR_DIV_HIGH:   rd_d = frac_q[FR_BRG_SEL] ? rx_div_hi_q : div_hi_q;
      ADDR_FRACTION:   rd_d = enh ? frac_q : 8'h00;
      ADDR_STATUS:     rd_d = {6'h00, halt_q, rx_fifo_error};
      default:         rd_d = 8'h00;
    endcase
  end

  // one wait state: pready rises the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      pready    <= psel && penable && !pready;
      pslverr   <= psel && penable && !pready && (paddr[1:0] != 2'b00 || paddr > ADDR_STATUS);
      if (psel && penable && !pready) begin
        prdata <= {24'h00_0000, rd_d};
      end
    end
  end

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ((|delta_q) && ctl_q[CTL_MSI_ENABLE]) |=> modem_irq) else $error("modem irq missing");
  a_scratch_rst: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> scratch_q == SCRATCH_RST) else $error("scratch reset wrong");
  a_enh_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_MODEM_LINE && !enh) |=> $stable(tx_disable)) else $error("guard");
  a_err_sum: assert property (@(posedge pclk) disable iff (!presetn)
    rx_fifo_error |=> error_summary) else $error("error summary lag");
  a_send_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_char_done && ems_q[EMS_SEND_NOW] && !wr) |=> !ems_q[EMS_SEND_NOW]) else $error("send");
  a_loop_map: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_q[CTL_LOOPBACK] |-> status_hi[2:0] == {mcr_q[2], mcr_q[0], mcr_q[1]}) else $error("lb");
  a_norm_map: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_q[CTL_LOOPBACK] |-> status_hi == level_now) else $error("level map");
  a_ri_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (!delta_q[2] && modem_prev_q[2] == status_hi[2]) |=> !delta_q[2]) else $error("ri");

  // bus answer is a single-cycle pulse
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready longer than one cycle");
  a_delta_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == ADDR_MODEM_LINE && !modem_ev[0]) |=> !delta_q[0]) else $error("delta kept");
  a_alt_first: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_SCRATCH && ctl_q[CTL_SWAP]) |=> !alt_tx_q) else $error("alt start");
  a_rts_dir: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_q[CTL_RS485] |=> rts_n_rs485 == ($past(tx_active) ~^ $past(ems_q[EMS_RTS_INV])))
    else $error("rs485 direction");
  a_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!halt_q && tx_active && !tx_char_done) |=> !halt_q) else $error("halt mid character");
  a_frac_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_FRACTION && !enh) |=> $stable(frac_q)) else $error("fraction guard");
  a_scr_swap: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_SCRATCH && ctl_q[CTL_SWAP]) |=> $stable(scratch_q)) else $error("swap");
  a_level_src: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == ADDR_SCRATCH && ctl_q[CTL_SWAP] && !ems_q[0])
    |=> prdata[7:0] == $past(rx_level)) else $error("rx level read");
  a_err_low: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_fifo_error |=> !error_summary) else $error("error summary stuck");
endmodule

/* sim/testbench.sv */
// testbench: apb register tests for umsr_regs
`timescale 1ns/1ps
module testbench;
  import umsr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  want_n = 4'hF;
  umsr_modem_t modem_in;
  logic [7:0]  rx_level = 8'h05;
  logic [7:0]  tx_level = 8'h0B;
  logic        rx_fifo_error = 1'b0;
  logic        tx_char_done = 1'b0;
  logic        tx_active = 1'b0;
  logic        modem_irq, tx_halt, tx_disable, rx_disable, nine_bit_mode, fast_ir;
  logic        send_now, rts_n_rs485, lsr_irq_immediate, xoff_clear_on_read_only;
  logic        error_summary;
  umsr_brg_t   tx_brg, rx_brg;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [31:0] r;
  logic        e;
  umsr_rate_t  rt;

  always #4 pclk = ~pclk;

  umsr_modem_far far (.pclk(pclk), .presetn(presetn), .want_n(want_n), .lines(modem_in));

  umsr_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_in(modem_in), .rx_level(rx_level), .tx_level(tx_level),
    .rx_fifo_error(rx_fifo_error), .tx_char_done(tx_char_done), .tx_active(tx_active),
    .modem_irq(modem_irq), .tx_halt(tx_halt), .tx_disable(tx_disable),
    .rx_disable(rx_disable), .nine_bit_mode(nine_bit_mode), .fast_ir(fast_ir),
    .send_now(send_now), .rts_n_rs485(rts_n_rs485), .lsr_irq_immediate(lsr_irq_immediate),
    .xoff_clear_on_read_only(xoff_clear_on_read_only), .error_summary(error_summary),
    .tx_brg(tx_brg), .rx_brg(rx_brg)
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 2);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // registered outputs follow a write one edge after it lands
    repeat (2) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(r[7:0], x);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #50000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(rts_n_rs485, 1'b1);
    rc(ADDR_SCRATCH, SCRATCH_RST);
    rc(ADDR_MODEM_LINE, 8'h00);
    wr(ADDR_SCRATCH, 32'h5A);
    rc(ADDR_SCRATCH, 8'h5A);
    wr(ADDR_CONTROL, 32'h10);
    want_n <= 4'h7;
    tick(4);
    chk(modem_irq, 1'b1);
    rc(ADDR_MODEM_LINE, 8'h11);
    rc(ADDR_MODEM_LINE, 8'h10);
    chk(modem_irq, 1'b0);
    want_n <= 4'h2;
    tick(4);
    rc(ADDR_MODEM_LINE, 8'hBA);
    want_n <= 4'h0;
    tick(4);
    rc(ADDR_MODEM_LINE, 8'hF0);
    want_n <= 4'h2;
    tick(4);
    rc(ADDR_MODEM_LINE, 8'hB4);
    // loopback: control bits 12:9 carry the modem control nibble
    wr(ADDR_CONTROL, 32'h0A01);
    apb(1'b0, ADDR_MODEM_LINE, 32'h0);
    chk(r[7:4], 4'h6);
    wr(ADDR_CONTROL, 32'h1401);
    apb(1'b0, ADDR_MODEM_LINE, 32'h0);
    chk(r[7:4], 4'h9);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_MODEM_LINE, 32'hF0);
    chk(tx_disable, 1'b0);
    wr(ADDR_FRACTION, 32'h07);
    rc(ADDR_FRACTION, 8'h00);
    wr(ADDR_CONTROL, 32'h2);
    wr(ADDR_MODEM_LINE, 32'h70);
    chk({tx_disable, rx_disable, nine_bit_mode, fast_ir}, 4'hE);
    wr(ADDR_MODEM_LINE, 32'h80);
    chk({tx_disable, rx_disable, nine_bit_mode, fast_ir}, 4'h1);
    wr(ADDR_DIV_LOW, 32'h34);
    wr(ADDR_DIV_HIGH, 32'h12);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_FRACTION, 32'h09 | (i << 4));
      rt = (i == 0) ? UMSR_OS16 : (i == 1) ? UMSR_OS8 : UMSR_OS4;
      chk(tx_brg, {16'h1234, 4'h9, rt});
      chk(rx_brg, {16'h1234, 4'h9, rt});
    end
    wr(ADDR_FRACTION, 32'h40);
    wr(ADDR_DIV_LOW, 32'hAA);
    chk({tx_brg.divisor, rx_brg.divisor}, 32'h12AA1234);
    wr(ADDR_FRACTION, 32'hC0);
    wr(ADDR_DIV_LOW, 32'h55);
    chk({tx_brg.divisor, rx_brg.divisor}, 32'h12AA1255);
    wr(ADDR_FRACTION, 32'h80);
    wr(ADDR_DIV_LOW, 32'h77);
    chk({tx_brg.divisor, rx_brg.divisor}, 32'h12AA1255);
    // swap on: scratch writes go to mode select, reads give fifo levels
    wr(ADDR_CONTROL, 32'h0A);
    wr(ADDR_SCRATCH, 32'h01);
    rc(ADDR_SCRATCH, 8'h0B);
    wr(ADDR_SCRATCH, 32'h00);
    rc(ADDR_SCRATCH, 8'h05);
    wr(ADDR_SCRATCH, 32'h03);
    rc(ADDR_SCRATCH, 8'h05);
    rc(ADDR_SCRATCH, 8'h0B);
    rc(ADDR_SCRATCH, 8'h05);
    wr(ADDR_SCRATCH, 32'hC0);
    chk({lsr_irq_immediate, xoff_clear_on_read_only}, 2'b11);
    wr(ADDR_CONTROL, 32'h6A);
    tx_active <= 1'b1;
    tick(3);
    chk(rts_n_rs485, 1'b0);
    wr(ADDR_SCRATCH, 32'h0C);
    chk({send_now, rts_n_rs485}, 2'b11);
    tx_char_done <= 1'b1;
    @(posedge pclk);
    tx_char_done <= 1'b0;
    tick(2);
    chk(send_now, 1'b0);
    wr(ADDR_CONTROL, 32'h2);
    rc(ADDR_SCRATCH, 8'h5A);
    tx_active <= 1'b0;
    wr(ADDR_CONTROL, 32'h6);
    want_n <= 4'hA;
    tick(4);
    chk(tx_halt, 1'b1);
    want_n <= 4'h2;
    tick(4);
    chk(tx_halt, 1'b0);
    // cts goes inactive mid character: halt waits for the character to end
    tx_active <= 1'b1;
    want_n <= 4'hA;
    tick(4);
    chk(tx_halt, 1'b0);
    tx_char_done <= 1'b1;
    @(posedge pclk);
    tx_char_done <= 1'b0;
    tick(3);
    chk(tx_halt, 1'b1);
    tx_active <= 1'b0;
    want_n <= 4'h2;
    tick(4);
    chk(tx_halt, 1'b0);
    rx_fifo_error <= 1'b1;
    tick(3);
    chk(error_summary, 1'b1);
    rx_fifo_error <= 1'b0;
    tick(3);
    chk(error_summary, 1'b0);
    // unmapped place answers with an error and zero data
    apb(1'b0, 8'h20, 32'h0);
    chk({e, r[7:0]}, 9'h100);
    conclude();
  end
endmodule

/* sim/umsr_modem_far.sv */
// far-side modem model: drives the active-low modem lines
`timescale 1ns/1ps
module umsr_modem_far
  import umsr_pkg::*;
(
  input  wire logic [0:0]       pclk,
  input  wire logic [0:0]       presetn,
  input  wire logic [3:0]       want_n,
  output umsr_pkg::umsr_modem_t lines
);
  // lines change only after a clock edge, idle high (inactive) out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= '1;
    end else begin
      lines <= want_n;
    end
  end
endmodule
